// >>> design/xeip_regs.vh
`ifndef XEIP_REGS_VH
`define XEIP_REGS_VH
// ====================================================
// Special-function addresses
`define XEIP_CTRL_ADDR 8'hC0
`define XEIP_PORT_ADDR 8'hD8
// ====================================================
// Control register fields
`define XEIP_IRQ2_EDGE_SELECT 0
`define XEIP_IRQ2_PENDING 1
`define XEIP_IRQ2_ENABLE 2
`define XEIP_IRQ2_PRIORITY 3
`define XEIP_IRQ3_EDGE_SELECT 4
`define XEIP_IRQ3_PENDING 5
`define XEIP_IRQ3_ENABLE 6
`define XEIP_IRQ3_PRIORITY 7
// ====================================================
// Reset values
`define XEIP_CTRL_RESET 8'h00
`define XEIP_PORT_RESET 4'hF
// ====================================================
// Vectors of the seven sources
`define XEIP_VEC_EXT0 8'h03
`define XEIP_VEC_TMR0 8'h0B
`define XEIP_VEC_EXT1 8'h13
`define XEIP_VEC_TMR1 8'h1B
`define XEIP_VEC_SER 8'h23
`define XEIP_VEC_IRQ2 8'h33
`define XEIP_VEC_IRQ3 8'h3B
// ====================================================
// Timing
`define XEIP_MC_CYCLES 12
`endif

// >>> design/xeip_top.v
// Overview of operation
// - Control register sits at byte 0C0H; every bit set/clear by bit access.
// - Bit address 0C2H enables source 2; bits hold prio, enable, flag, type.
// - Source 2 requests only while its enable bit 2 is set.
// - Source 3 requests only while its enable bit 6 is set.
// - Source 2 priority bit set gives high level, clear gives low.
// - Source 3 priority bit set gives high level, clear gives low.
// - Source 2 type bit set selects falling edge, clear selects low level.
// - Source 3 type bit set selects falling edge, clear selects low level.
// - Edge mode: source 2 pending set by edge, cleared when vectored.
// - Edge mode: source 3 pending set by edge, cleared when vectored.
// - Source 2 vectors to 33H with polling rank 5.
// - Source 3 vectors to 3BH with polling rank 6, lowest.
// - Standard sources vector 03H,0BH,13H,1BH,23H with ranks 0 to 4.
// - Bit-addressable port at byte 0D8H, only low four bits are pins.
// - Port is quasi-bidirectional with pull-ups, latch written, pins read.
// - Port bits 3 and 2 double as the two extra interrupt inputs.
// - Reset sets the port latch to all ones.
// - Reset clears the control register to 00H.
`timescale 1ns/1ps
`include "xeip_regs.vh"
module xeip_top #(
  parameter MC_CYCLES = `XEIP_MC_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Special-function byte access
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_ff,
  // Special-function bit access
  input wire [7:0] bit_addr,
  input wire bit_wr,
  input wire bit_wdata,
  output reg bit_rdata_ff,
  // Standard sources: requests and priorities from the core
  input wire [4:0] std_req,
  input wire [4:0] std_prio,
  // Interrupt sequencer handshake
  input wire irq_ack,
  input wire irq_reti,
  output reg irq_req_ff,
  output reg [7:0] irq_vector_ff,
  output reg [2:0] irq_rank_ff,
  // Nibble port pins
  input wire [3:0] port_in,
  output reg [3:0] port_out_ff,
  output reg [3:0] port_oe_ff
);
// ====================================================
// Registers
reg [7:0] ctrl_ff;
reg [7:0] nxt_ctrl;
reg [3:0] latch_ff;
reg [3:0] nxt_latch;
reg [3:0] pin_s1_ff;
reg [3:0] pin_s2_ff;
reg [3:0] pin_d_ff;
reg [3:0] mc_cnt_ff;
reg mc_tick_ff;
reg [1:0] act_ff;
reg [1:0] nxt_act;
wire irq2_lvl;
wire irq3_lvl;
wire irq2_edge;
wire irq3_edge;
wire [6:0] req_all;
wire [6:0] hi_all;
reg [6:0] eligible;
reg [2:0] win_rank;
reg win_found;
reg [7:0] win_vec;
reg [7:0] vec_of;
integer i;
wire [7:0] ctrl_base;
wire [7:0] port_base;
wire ctrl_bit_hit;
wire port_bit_hit;
localparam [2:0] RANK_IRQ2 = 3'h5;
localparam [2:0] RANK_IRQ3 = 3'h6;
// ====================================================
// Pin synchronisers; pin status read back, not the latch
// Third flop only re-times the read path; interrupt logic uses the second
always @(posedge clk) begin
  if (!nrst) begin
    pin_s1_ff <= 4'hF;
    pin_s2_ff <= 4'hF;
    pin_d_ff <= 4'hF;
  end else begin
    pin_s1_ff <= port_in;
    pin_s2_ff <= pin_s1_ff;
    pin_d_ff <= pin_s2_ff;
  end
end
// ====================================================
// Machine cycle tick
// MC_CYCLES above 16 would overflow the 4-bit counter
always @(posedge clk) begin
  if (!nrst) begin
    mc_cnt_ff <= 4'h0;
    mc_tick_ff <= 1'b0;
  end else if (mc_cnt_ff == MC_CYCLES - 1) begin
    mc_cnt_ff <= 4'h0;
    mc_tick_ff <= 1'b1;
  end else begin
    mc_cnt_ff <= mc_cnt_ff + 4'h1;
    mc_tick_ff <= 1'b0;
  end
end
// ====================================================
// Extra interrupt samplers
// Sample held across the machine cycle, so an edge is seen once only
xeip_irq_sampler #(
  .IDLE_LEVEL(1'h1)
) irq2_sampler_inst (
  .clk(clk),
  .nrst(nrst),
  .tick(mc_tick_ff),
  .pin(pin_s2_ff[3]),
  .lvl(irq2_lvl),
  .edge_seen(irq2_edge)
);
xeip_irq_sampler #(
  .IDLE_LEVEL(1'h1)
) irq3_sampler_inst (
  .clk(clk),
  .nrst(nrst),
  .tick(mc_tick_ff),
  .pin(pin_s2_ff[2]),
  .lvl(irq3_lvl),
  .edge_seen(irq3_edge)
);
// ====================================================
// Bit addresses share the upper five bits of their byte address
assign ctrl_base = `XEIP_CTRL_ADDR;
assign port_base = `XEIP_PORT_ADDR;
assign ctrl_bit_hit = (bit_addr[7:3] == ctrl_base[7:3]);
assign port_bit_hit = (bit_addr[7:3] == port_base[7:3]) &
  ~bit_addr[2];
// ====================================================
// Request vector, index is the polling rank
// Level mode passes the live sample; edge mode the pending flag
assign req_all[4:0] = std_req;
assign req_all[5] = ctrl_ff[`XEIP_IRQ2_ENABLE] &
  (ctrl_ff[`XEIP_IRQ2_EDGE_SELECT] ? ctrl_ff[`XEIP_IRQ2_PENDING] :
   irq2_lvl);
assign req_all[6] = ctrl_ff[`XEIP_IRQ3_ENABLE] &
  (ctrl_ff[`XEIP_IRQ3_EDGE_SELECT] ? ctrl_ff[`XEIP_IRQ3_PENDING] :
   irq3_lvl);
assign hi_all[4:0] = std_prio;
assign hi_all[5] = ctrl_ff[`XEIP_IRQ2_PRIORITY];
assign hi_all[6] = ctrl_ff[`XEIP_IRQ3_PRIORITY];
// ====================================================
// Vector table
always @* begin
  vec_of = `XEIP_VEC_EXT0;
  case (win_rank)
    3'h0: vec_of = `XEIP_VEC_EXT0;
    3'h1: vec_of = `XEIP_VEC_TMR0;
    3'h2: vec_of = `XEIP_VEC_EXT1;
    3'h3: vec_of = `XEIP_VEC_TMR1;
    3'h4: vec_of = `XEIP_VEC_SER;
    RANK_IRQ2: vec_of = `XEIP_VEC_IRQ2;
    RANK_IRQ3: vec_of = `XEIP_VEC_IRQ3;
    default: vec_of = `XEIP_VEC_EXT0;
  endcase
  win_vec = vec_of;
end
// ====================================================
// Arbitration: high level first, then lowest rank
// act_ff bit 1: high service running, bit 0: low service running
always @* begin
  eligible = 7'h00;
  win_rank = 3'h0;
  win_found = 1'h0;
  if (!act_ff[1]) begin
    if (|(req_all & hi_all)) begin
      eligible = req_all & hi_all;
    end else if (!act_ff[0]) begin
      eligible = req_all;
    end
  end
  // Downward scan: the last hit is the lowest rank
  for (i = 6; i >= 0; i = i - 1) begin
    if (eligible[i]) begin
      win_rank = i[2:0];
      win_found = 1'b1;
    end
  end
end
// ====================================================
// Service level tracking
// One nesting level: high pre-empts low, nothing pre-empts high
always @* begin
  nxt_act = act_ff;
  if (irq_ack && irq_req_ff) begin
    if (hi_all[irq_rank_ff]) begin
      nxt_act[1] = 1'b1;
    end else begin
      nxt_act[0] = 1'b1;
    end
  end else if (irq_reti) begin
    if (act_ff[1]) begin
      nxt_act[1] = 1'b0;
    end else begin
      nxt_act[0] = 1'b0;
    end
  end
end
always @(posedge clk) begin
  if (!nrst) begin
    act_ff <= 2'b00;
    irq_req_ff <= 1'h0;
    irq_vector_ff <= 8'h00;
    irq_rank_ff <= 3'h0;
  end else begin
    act_ff <= nxt_act;
    if (irq_ack && irq_req_ff) begin
      irq_req_ff <= 1'b0;
    end else begin
      irq_req_ff <= win_found;
      irq_vector_ff <= win_vec;
      irq_rank_ff <= win_rank;
    end
  end
end
// ====================================================
// Control register and port latch, byte and bit access
always @* begin
  nxt_ctrl = ctrl_ff;
  nxt_latch = latch_ff;
  if (sfr_wr && sfr_addr == `XEIP_CTRL_ADDR) begin
    nxt_ctrl = sfr_wdata;
  end
  if (sfr_wr && sfr_addr == `XEIP_PORT_ADDR) begin
    nxt_latch = sfr_wdata[3:0];
  end
  // Bit write after byte write, so the bit write wins a shared cycle
  if (bit_wr && ctrl_bit_hit) begin
    nxt_ctrl[bit_addr[2:0]] = bit_wdata;
  end
  if (bit_wr && port_bit_hit) begin
    nxt_latch[bit_addr[1:0]] = bit_wdata;
  end
  // Vectoring clears edge flags; a new edge in that cycle still wins
  if (irq_ack && irq_req_ff && irq_rank_ff == RANK_IRQ2 &&
      ctrl_ff[`XEIP_IRQ2_EDGE_SELECT]) begin
    nxt_ctrl[`XEIP_IRQ2_PENDING] = 1'b0;
  end
  if (irq_ack && irq_req_ff && irq_rank_ff == RANK_IRQ3 &&
      ctrl_ff[`XEIP_IRQ3_EDGE_SELECT]) begin
    nxt_ctrl[`XEIP_IRQ3_PENDING] = 1'b0;
  end
  if (irq2_edge && ctrl_ff[`XEIP_IRQ2_EDGE_SELECT]) begin
    nxt_ctrl[`XEIP_IRQ2_PENDING] = 1'b1;
  end
  if (irq3_edge && ctrl_ff[`XEIP_IRQ3_EDGE_SELECT]) begin
    nxt_ctrl[`XEIP_IRQ3_PENDING] = 1'b1;
  end
end
always @(posedge clk) begin
  if (!nrst) begin
    ctrl_ff <= `XEIP_CTRL_RESET;
    latch_ff <= `XEIP_PORT_RESET;
  end else begin
    ctrl_ff <= nxt_ctrl;
    latch_ff <= nxt_latch;
  end
end
// ====================================================
// Read path: registered, one cycle after the strobe
always @(posedge clk) begin
  if (!nrst) begin
    sfr_rdata_ff <= 8'h00;
    bit_rdata_ff <= 1'b0;
  end else begin
    if (sfr_rd) begin
      if (sfr_addr == `XEIP_CTRL_ADDR) begin
        sfr_rdata_ff <= ctrl_ff;
      end else if (sfr_addr == `XEIP_PORT_ADDR) begin
        sfr_rdata_ff <= {4'h0, pin_d_ff};
      end else begin
        sfr_rdata_ff <= 8'h00;
      end
    end
    // Bit read data follows bit_addr every cycle, no strobe needed
    if (ctrl_bit_hit) begin
      bit_rdata_ff <= ctrl_ff[bit_addr[2:0]];
    end else if (port_bit_hit) begin
      bit_rdata_ff <= pin_d_ff[bit_addr[1:0]];
    end else begin
      bit_rdata_ff <= 1'b0;
    end
  end
end
// ====================================================
// Quasi-bidirectional drive: pull low strongly, release for a one
// Simplified: no brief strong-high pulse on a 0-to-1 change
always @(posedge clk) begin
  if (!nrst) begin
    port_out_ff <= 4'h0;
    port_oe_ff <= 4'h0;
  end else begin
    port_out_ff <= 4'h0;
    port_oe_ff <= ~nxt_latch;
  end
end
endmodule // xeip_top

// ====================================================
// One extra interrupt input: machine-cycle sample and edge strobe
module xeip_irq_sampler #(
  parameter [0:0] IDLE_LEVEL = 1'h1
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Machine-cycle tick and synchronised pin level
  input wire tick,
  input wire pin,
  // Low-level request and falling-edge strobe
  output wire lvl,
  output wire edge_seen
);
reg smp_ff;
reg lvl_ff;
// Previous sample starts at the idle level, so reset gives no false edge
always @(posedge clk) begin
  if (!nrst) begin
    smp_ff <= IDLE_LEVEL;
    lvl_ff <= ~IDLE_LEVEL;
  end else if (tick) begin
    smp_ff <= pin;
    lvl_ff <= ~pin;
  end
end
// Level mode follows the sample and is never latched
assign lvl = lvl_ff;
assign edge_seen = tick & smp_ff & ~pin;
endmodule // xeip_irq_sampler

// >>> testbench/xeip_core_model.sv
`timescale 1ns/1ps
// ==========
// Core sequencer and external pin sources
module xeip_core_model #(
  parameter ACK_WAIT = 2,
  parameter SERVICE = 4
) (
  // Design side
  input wire clk,
  input wire irq_req_ff,
  input wire [7:0] irq_vector_ff,
  input wire [3:0] port_oe_ff,
  output reg irq_ack = 1'b0,
  output reg irq_reti = 1'b0,
  output wire [3:0] port_in,
  // Bench control
  input wire ack_en,
  input wire [3:0] ext_low,
  output reg [7:0] taken_vec = 8'h00
);
  // Released pins go to the pull-up level, never a stale value
  assign port_in = ~(port_oe_ff | ext_low);
  // One routine at a time; the wait shows the request holding
  // Sampled at the falling edge, where the registered outputs have settled;
  // the vector is held through the ack edge, so it is read just after it
  always begin
    @(negedge clk);
    if (ack_en && irq_req_ff) begin
      repeat (ACK_WAIT - 1) @(negedge clk);
      irq_ack = 1'b1;
      @(negedge clk);
      taken_vec = irq_vector_ff;
      irq_ack = 1'b0;
      repeat (SERVICE) @(negedge clk);
      irq_reti = 1'b1;
      @(negedge clk);
      irq_reti = 1'b0;
    end
  end
endmodule // xeip_core_model

// >>> testbench/xeip_sva.sv
`timescale 1ns/1ps
// ==========
// Port checker
module xeip_checker (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register access
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_ff,
  input wire bit_wr,
  input wire bit_wdata,
  input wire [7:0] bit_addr,
  input wire bit_rdata_ff,
  // Interrupt handshake
  input wire irq_ack,
  input wire irq_req_ff,
  input wire [7:0] irq_vector_ff,
  input wire [2:0] irq_rank_ff,
  // Pins
  input wire [3:0] port_in,
  input wire [3:0] port_out_ff,
  input wire [3:0] port_oe_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Pins pass two synchronisers, so a read needs a settled history
  sequence s_pins_hold;
    $stable(port_in) [*5];
  endsequence
  sequence s_c2_set;
    bit_wr && bit_addr == 8'hC2 ##1 bit_addr == 8'hC2;
  endsequence
  property p_rst;
    $rose(nrst) |-> port_oe_ff == 4'h0 && !irq_req_ff;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_pull;
    port_out_ff == 4'h0;
  endproperty
  a_pull: assert property (p_pull) else $error("pin driven");
  property p_unmap;
    sfr_rd && sfr_addr != 8'hC0 && sfr_addr != 8'hD8 |=> sfr_rdata_ff == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_latch;
    sfr_wr && !bit_wr && sfr_addr == 8'hD8
      |=> {4'h0, port_oe_ff} == (8'h0F & ~$past(sfr_wdata));
  endproperty
  a_latch: assert property (p_latch) else $error("latch write");
  property p_pins;
    s_pins_hold ##0 sfr_rd && sfr_addr == 8'hD8
      |=> sfr_rdata_ff == {4'h0, $past(port_in)};
  endproperty
  a_pins: assert property (p_pins) else $error("pin read");
  property p_bit;
    s_c2_set |=> bit_rdata_ff == $past(bit_wdata, 2);
  endproperty
  a_bit: assert property (p_bit) else $error("bit access");
  property p_ack;
    irq_ack && irq_req_ff |=> !irq_req_ff;
  endproperty
  a_ack: assert property (p_ack) else $error("ack");
  // Ranks 5 and 6 skip one vector slot
  property p_vec;
    irq_req_ff |-> irq_vector_ff ==
      {2'h0, (irq_rank_ff > 3'h4 ? irq_rank_ff + 3'h1 : irq_rank_ff), 3'h3};
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
endmodule // xeip_checker
bind xeip_top xeip_checker xeip_checker_inst (.*);

// >>> testbench/xeip_top_tb.sv
`timescale 1ns/1ps
// ==========
// Bench
module xeip_top_tb;
  reg clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  reg bit_wr = 1'b0, bit_wdata = 1'b0, ack_en = 1'b0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  reg [4:0] std_req = 5'h00, std_prio = 5'h00;
  reg [3:0] ext_low = 4'h0;
  wire irq_ack, irq_reti, irq_req_ff, bit_rdata_ff;
  wire [7:0] sfr_rdata_ff, irq_vector_ff, taken_vec;
  wire [2:0] irq_rank_ff;
  wire [3:0] port_in, port_out_ff, port_oe_ff;
  integer errors = 0, comparisons = 0, i;
  always #5 clk = ~clk;
  // Short machine cycle keeps pin latency small
  xeip_top #(.MC_CYCLES(2)) xeip_top_inst (.*);
  xeip_core_model xeip_core_model_inst (.*);
  // ==========
  // Tasks
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk); sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
      @(negedge clk); sfr_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(negedge clk); sfr_addr = a; sfr_rd = 1'b1;
      @(negedge clk); sfr_rd = 1'b0;
      chk(sfr_rdata_ff, exp);
    end
  endtask
  task bw(input [7:0] a, input v);
    begin
      @(negedge clk); bit_addr = a; bit_wdata = v; bit_wr = 1'b1;
      @(negedge clk); bit_wr = 1'b0;
      @(negedge clk);
    end
  endtask
  task pulse(input [3:0] m);
    begin
      ext_low = m;
      cyc(20);
      ext_low = 4'h0;
      cyc(20);
    end
  endtask
  task see(input [3:0] m, input [7:0] exp);
    begin
      ext_low = m;
      cyc(20);
      chk(irq_vector_ff, exp);
    end
  endtask
  task tally_and_finish;
    begin
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ==========
  // Watchdog, well beyond the few hundred cycles of the tests
  initial begin
    repeat (3000) @(posedge clk);
    errors = errors + 1;
    tally_and_finish;
  end
  // ==========
  // Tests
  initial begin
    cyc(16);
    nrst = 1'b1;
    rd(8'hC0, 8'h00);
    rd(8'h80, 8'h00);
    bw(8'hC2, 1'b1);
    rd(8'hC0, 8'h04);
    wr(8'hD8, 8'h0A);
    cyc(6);
    rd(8'hD8, 8'h0A);
    wr(8'hD8, 8'h0F);
    cyc(6);
    rd(8'hD8, 8'h0F);
    wr(8'hC0, 8'h01);
    pulse(4'h8);
    rd(8'hC0, 8'h03);
    chk(irq_req_ff, 8'h00);
    ack_en = 1'b1;
    bw(8'hC2, 1'b1);
    cyc(20);
    chk(taken_vec, 8'h33);
    rd(8'hC0, 8'h05);
    wr(8'hC0, 8'h50);
    pulse(4'h4);
    chk(taken_vec, 8'h3B);
    rd(8'hC0, 8'h50);
    ack_en = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      std_req = 5'h01 << i;
      cyc(10);
      chk(irq_vector_ff, {i[4:0], 3'b011});
    end
    std_req = 5'h14;
    std_prio = 5'h10;
    cyc(5);
    chk(irq_vector_ff, 8'h23);
    std_prio = 5'h00;
    wr(8'hC0, 8'h0C);
    see(4'h8, 8'h33);
    wr(8'hC0, 8'h04);
    see(4'h8, 8'h13);
    std_req = 5'h01;
    wr(8'hC0, 8'hC0);
    see(4'h4, 8'h3B);
    wr(8'hC0, 8'h80);
    see(4'h4, 8'h03);
    std_req = 5'h00;
    wr(8'hC0, 8'h40);
    see(4'h4, 8'h3B);
    chk(irq_req_ff, 8'h01);
    ext_low = 4'h0;
    cyc(20);
    chk(irq_req_ff, 8'h00);
    tally_and_finish;
  end
endmodule // xeip_top_tb
